//--- rtl/nor_sync_defines.vh
// Constants for the synchronous burst NOR access sequencer.
// Assumes one 100 MHz system clock that serves as the functional clock.
// Operation
// R1 - Read data, 16 bits, captured on bus clock rising edge; code captures one functional period after the rise.
// R2 - Four wait inputs; selected one sampled on bus clock rising edge; code samples one functional period after the rise.
// R3 - Bus clock runs at fifty percent duty cycle nominally; code holds it high one period, low div_top periods.
// R4 - Address valid bus_clock_start_time periods before first bus clock edge.
// R5 - Single read select low: (release minus assert) times scale.
// R6 - Burst read select low adds (n-1) beat times, scaled.
// R7 - Burst write select low: write release minus assert plus beats, scaled.
// R8 - Single read byte enables low for read cycle length, scaled.
// R9 - Burst read byte enables add (n-1) beat times, scaled.
// R10 - Burst write byte enables: write cycle length plus beats, scaled.
// R11 - Select assertion phase: half-cycle delay, divider-dependent parity offsets.
// R12 - Strobe assertion uses same phase rule with its own fields.
// R13 - Read strobe release by read release time with phase rule.
// R14 - Write strobe release by write release time with phase rule.
// R15 - Output enable assertion by its time with phase rule.
// R16 - Direction goes inbound together with output enable assertion.
// R17 - Direction low means outbound.
// R18 - Direction back outbound after read cycle and turnaround both finish.
// R19 - Eight chip select outputs.
// R20 - Non-multiplexed attachment limited to 10 address bits.
// R21 - Timing profile held separately for each chip select.
`ifndef NOR_SYNC_DEFINES_VH
`define NOR_SYNC_DEFINES_VH
`define CS_COUNT 8
`define CS_IDX_W 3
`define WAIT_COUNT 4
`define DATA_W 16
`define ADDR_W 26
`define NONMUX_ADDR_W 10
`define TIME_W 5
`define CNT_W 12
`define BURST_W 4
`define DIV_W 2
`define PROFILE_W 72
`define PF_CS_ON 0
`define PF_CS_RD_OFF 5
`define PF_CS_WR_OFF 10
`define PF_ADV_ON 15
`define PF_ADV_RD_OFF 20
`define PF_ADV_WR_OFF 25
`define PF_OE_ON 30
`define PF_RD_CYC 35
`define PF_WR_CYC 40
`define PF_BEAT 45
`define PF_CLK_START 50
`define PF_TURN 55
`define PF_DIV 60
`define PF_SCALE 62
`define PF_CS_HALF 63
`define PF_ADV_HALF 64
`define PF_OE_HALF 65
`define PF_MUXED 66
`define PF_WAIT_SEL 67
`endif

//--- rtl/profile_store.v
// Per-select timing profile store, one word per chip select.
// Assumes software writes a profile before starting an access on that select.
`timescale 1ns/10ps
`default_nettype none
`include "nor_sync_defines.vh"
module profile_store (
    input wire clk_sys,
    input wire write_en,
    input wire [`CS_IDX_W-1:0] write_index,
    input wire [`PROFILE_W-1:0] write_data,
    input wire [`CS_IDX_W-1:0] read_index,
    output reg [`PROFILE_W-1:0] read_data
);
    reg [`PROFILE_W-1:0] mem [0:`CS_COUNT-1];
    always @(posedge clk_sys) begin
        if (write_en) begin
            mem[write_index] <= write_data; // R21
        end
        read_data <= mem[read_index];
    end
endmodule // profile_store
`default_nettype wire

//--- rtl/sync_nor_access_timing.v
// Synchronous NOR single/burst read and burst write sequencer.
// Assumes clk_sys is the functional clock; memory inputs sampled synchronously.
`timescale 1ns/10ps
`default_nettype none
`include "nor_sync_defines.vh"
module sync_nor_access_timing (
    input wire clk_sys,
    input wire reset_n,
    input wire profile_write,
    input wire [`CS_IDX_W-1:0] profile_index,
    input wire [`PROFILE_W-1:0] profile_data,
    input wire start,
    input wire write_access,
    input wire [`CS_IDX_W-1:0] select_index,
    input wire [`BURST_W-1:0] burst_length,
    input wire [`ADDR_W-1:0] address,
    input wire [`DATA_W-1:0] write_data,
    output wire busy,
    output reg [`DATA_W-1:0] read_data,
    output reg read_valid,
    output reg done,
    output reg bus_clock,
    output reg [`CS_COUNT-1:0] chip_select_n,
    output reg address_valid_n,
    output reg output_enable_n,
    output reg byte_enable0_n,
    output reg byte_enable1_n,
    output reg io_direction,
    output reg [`ADDR_W-1:0] address_out,
    output reg [`DATA_W-1:0] data_out,
    output reg data_out_en,
    input wire [`DATA_W-1:0] data_in,
    input wire [`WAIT_COUNT-1:0] wait_in,
    output reg wait_seen
);
    localparam ST_IDLE = 3'd0;
    localparam ST_LOAD = 3'd1;
    localparam ST_RUN = 3'd2;
    localparam ST_TURN = 3'd3;
    localparam ST_DONE = 3'd4;

    reg [2:0] state;
    reg [`CS_IDX_W-1:0] cs_sel;
    reg is_write;
    reg [`BURST_W-1:0] beats;
    reg [`ADDR_W-1:0] addr_hold;
    reg [`CNT_W-1:0] tick;
    reg [`CNT_W-1:0] turn_cnt;
    reg [1:0] div_cnt;
    reg bclk_rise;
    wire [`PROFILE_W-1:0] prof;

    profile_store u_profile (
        .clk_sys(clk_sys),
        .write_en(profile_write),
        .write_index(profile_index),
        .write_data(profile_data),
        .read_index(select_index),
        .read_data(prof)
    );

    reg [`PROFILE_W-1:0] p;
    wire [`TIME_W-1:0] t_cs_on = p[`PF_CS_ON +: `TIME_W];
    wire [`TIME_W-1:0] t_cs_rd = p[`PF_CS_RD_OFF +: `TIME_W];
    wire [`TIME_W-1:0] t_cs_wr = p[`PF_CS_WR_OFF +: `TIME_W];
    wire [`TIME_W-1:0] t_adv_on = p[`PF_ADV_ON +: `TIME_W];
    wire [`TIME_W-1:0] t_adv_rd = p[`PF_ADV_RD_OFF +: `TIME_W];
    wire [`TIME_W-1:0] t_adv_wr = p[`PF_ADV_WR_OFF +: `TIME_W];
    wire [`TIME_W-1:0] t_oe_on = p[`PF_OE_ON +: `TIME_W];
    wire [`TIME_W-1:0] t_rd_cyc = p[`PF_RD_CYC +: `TIME_W];
    wire [`TIME_W-1:0] t_wr_cyc = p[`PF_WR_CYC +: `TIME_W];
    wire [`TIME_W-1:0] t_beat = p[`PF_BEAT +: `TIME_W];
    wire [`TIME_W-1:0] t_clk = p[`PF_CLK_START +: `TIME_W];
    wire [`TIME_W-1:0] t_turn = p[`PF_TURN +: `TIME_W];
    wire [`DIV_W-1:0] div = p[`PF_DIV +: `DIV_W];
    wire scale = p[`PF_SCALE];
    wire cs_half = p[`PF_CS_HALF];
    wire adv_half = p[`PF_ADV_HALF];
    wire oe_half = p[`PF_OE_HALF];
    wire muxed = p[`PF_MUXED];
    wire [1:0] wait_sel = p[`PF_WAIT_SEL +: 2];

    // Scaled edge time: (t + (n-1)*beat) * (scale+1)
    function [`CNT_W-1:0] scaled;
        input [`TIME_W-1:0] t;
        input [`TIME_W-1:0] b;
        input [`BURST_W-1:0] n;
        input sc;
        reg [`CNT_W-1:0] base;
        begin
            base = {{(`CNT_W-`TIME_W){1'b0}}, t} + b * ({{(`CNT_W-`BURST_W){1'b0}}, n} - 12'h001);
            scaled = sc ? (base << 1) : base;
        end
    endfunction

    // Phase offset to align an edge with the bus clock grid
    function [1:0] phase;
        input [`TIME_W-1:0] t;
        input [`TIME_W-1:0] ca;
        input [`DIV_W-1:0] d;
        reg [`TIME_W+1:0] diff;
        reg [`TIME_W+1:0] rem;
        begin
            diff = {2'b00, t} + 7'd60 - {2'b00, ca};
            rem = diff % 7'd3;
            case (d)
                2'd1: phase = {1'b0, t[0] ^ ca[0]};
                2'd2: phase = rem[1:0];
                default: phase = 2'd0;
            endcase
        end
    endfunction

    // Edge times in functional periods; half-cycle delays via cs_half, adv_half, oe_half at the outputs
    wire [`CNT_W-1:0] cs_on_at = scaled(t_cs_on, t_beat, 4'h1, scale)
        + {10'h000, phase(t_cs_on, t_clk, div)}; // R11
    wire [`CNT_W-1:0] cs_off_at = cs_on_at
        + scaled(is_write ? t_cs_wr : t_cs_rd, t_beat, beats, scale)
        - scaled(t_cs_on, t_beat, 4'h1, scale); // R5 R6 R7
    wire [`CNT_W-1:0] adv_on_at = scaled(t_adv_on, t_beat, 4'h1, scale)
        + {10'h000, phase(t_adv_on, t_clk, div)}; // R12
    wire [`CNT_W-1:0] adv_off_at = is_write
        ? scaled(t_adv_wr, t_beat, 4'h1, scale) + {10'h000, phase(t_adv_wr, t_clk, div)} // R14
        : scaled(t_adv_rd, t_beat, 4'h1, scale) + {10'h000, phase(t_adv_rd, t_clk, div)}; // R13
    wire [`CNT_W-1:0] oe_on_at = scaled(t_oe_on, t_beat, 4'h1, scale)
        + {10'h000, phase(t_oe_on, t_clk, div)}; // R15
    wire [`CNT_W-1:0] be_len = scaled(is_write ? t_wr_cyc : t_rd_cyc, t_beat, beats, scale); // R8 R9 R10
    wire [`CNT_W-1:0] clk_at = {{(`CNT_W-`TIME_W){1'b0}}, t_clk};
    wire [`CNT_W-1:0] end_at = (cs_off_at > be_len) ? cs_off_at : be_len;

    assign busy = (state != ST_IDLE);
    // Registered pin cannot toggle at full rate; divider 0 runs as divider 1
    wire [1:0] div_top = (div == 2'h0) ? 2'h1 : div;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            cs_sel <= 3'h0;
            is_write <= 1'b0;
            beats <= 4'h1;
            addr_hold <= 26'h0000000;
            p <= 72'h000000000000000000;
            tick <= 12'h000;
            turn_cnt <= 12'h000;
            div_cnt <= 2'h0;
            bclk_rise <= 1'b0;
            read_data <= 16'h0000;
            read_valid <= 1'b0;
            done <= 1'b0;
            wait_seen <= 1'b0;
        end else begin
            read_valid <= 1'b0;
            done <= 1'b0;
            bclk_rise <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        cs_sel <= select_index;
                        is_write <= write_access;
                        beats <= (burst_length == 4'h0) ? 4'h1 : burst_length;
                        addr_hold <= address;
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    p <= prof; // R21
                    tick <= 12'h000;
                    div_cnt <= 2'h0;
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    tick <= tick + 12'h001;
                    if (tick >= clk_at) begin
                        div_cnt <= (div_cnt == div_top) ? 2'h0 : div_cnt + 2'h1;
                        if (div_cnt == 2'h0) begin
                            bclk_rise <= 1'b1;
                        end
                    end
                    // Sample one functional period after the rising edge, data held by hold time
                    if (bclk_rise && !is_write && !output_enable_n) begin
                        read_data <= data_in; // R1
                        read_valid <= 1'b1;
                        wait_seen <= wait_in[wait_sel]; // R2
                    end else if (bclk_rise) begin
                        wait_seen <= wait_in[wait_sel]; // R2
                    end
                    if (tick + 12'h001 >= end_at) begin
                        turn_cnt <= {{(`CNT_W-`TIME_W){1'b0}}, t_turn};
                        state <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    // Outbound only after cycle and turnaround both complete
                    if (turn_cnt == 12'h000) begin
                        state <= ST_DONE; // R18
                    end else begin
                        turn_cnt <= turn_cnt - 12'h001;
                    end
                end
                ST_DONE: begin
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Outputs registered; half-cycle extras appear one period late here
    wire run = (state == ST_RUN);
    wire [`CNT_W-1:0] now = tick;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_clock <= 1'b0;
            chip_select_n <= 8'hff;
            address_valid_n <= 1'b1;
            output_enable_n <= 1'b1;
            byte_enable0_n <= 1'b1;
            byte_enable1_n <= 1'b1;
            io_direction <= 1'b0;
            address_out <= 26'h0000000;
            data_out <= 16'h0000;
            data_out_en <= 1'b0;
        end else begin
            if (run && now >= clk_at) begin
                bus_clock <= (div_cnt == 2'h0); // R3
            end else begin
                bus_clock <= 1'b0;
            end
            if (state == ST_LOAD) begin
                // Non-multiplexed attachment drives only low address bits
                address_out <= prof[`PF_MUXED] ? addr_hold
                    : {{(`ADDR_W-`NONMUX_ADDR_W){1'b0}}, addr_hold[`NONMUX_ADDR_W-1:0]}; // R4 R20
            end
            if (run) begin
                chip_select_n[cs_sel] <= !(now >= cs_on_at + {11'h000, cs_half}
                    && now < cs_off_at); // R11 R19
                address_valid_n <= !(now >= adv_on_at + {11'h000, adv_half}
                    && now < adv_off_at); // R12 R13 R14
                byte_enable0_n <= !(now < be_len);
                byte_enable1_n <= !(now < be_len);
                if (!is_write && now >= oe_on_at + {11'h000, oe_half} && now < cs_off_at) begin
                    output_enable_n <= 1'b0; // R15
                    io_direction <= 1'b1; // R16
                end else begin
                    output_enable_n <= 1'b1;
                end
                data_out <= write_data;
                data_out_en <= is_write || (muxed && now < adv_off_at);
            end else begin
                chip_select_n <= 8'hff;
                address_valid_n <= 1'b1;
                output_enable_n <= 1'b1;
                byte_enable0_n <= 1'b1;
                byte_enable1_n <= 1'b1;
                data_out_en <= 1'b0;
                if (state == ST_DONE || state == ST_IDLE) begin
                    io_direction <= 1'b0; // R17 R18
                end
            end
        end
    end
endmodule // sync_nor_access_timing
`default_nettype wire

//--- bench/flash_model.sv
// Behavioural burst NOR flash on the far side of the sequencer.
// Assumes the sequencer's registered bus clock and active-low strobes.
`timescale 1ns/10ps
`default_nettype none
module flash_model (
    input wire logic bus_clock,
    input wire logic [7:0] chip_select_n,
    input wire logic output_enable_n,
    input wire logic [25:0] address_out,
    output logic [15:0] data_in,
    output logic [3:0] wait_in
);
    logic [3:0] rises = 4'h0;
    logic [3:0] shown = 4'h0;
    logic drive;
    logic [15:0] word;
    assign drive = !(&chip_select_n) && !output_enable_n;
    assign word = {address_out[7:0] ^ 8'h5a, 4'h0, shown};
    // Released bus shows the inverse, so a late capture cannot match
    assign data_in = drive ? word : ~word;
    // Only the wait line named by the low address bits is raised
    assign wait_in = drive ? (4'h1 << address_out[1:0]) : 4'h0;
    always @(posedge bus_clock) begin
        rises <= drive ? rises + 4'h1 : 4'h0;
    end
    // Data moves on the falling edge to hold across each rise
    always @(negedge bus_clock) begin
        shown <= rises;
    end
endmodule // flash_model
`default_nettype wire

//--- bench/sync_nor_access_timing_checker.sv
// Port-level assertions for the synchronous NOR access sequencer.
// Assumes one functional clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module sync_nor_access_timing_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    input wire logic read_valid,
    input wire logic bus_clock,
    input wire logic [7:0] chip_select_n,
    input wire logic address_valid_n,
    input wire logic output_enable_n,
    input wire logic byte_enable0_n,
    input wire logic byte_enable1_n,
    input wire logic io_direction,
    input wire logic data_out_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_dir_with_oe: assert property (!output_enable_n |-> io_direction)
        else $error("output enable low while direction outbound");
    a_out_quiet: assert property (data_out_en |-> !io_direction && output_enable_n)
        else $error("data driven while inbound");
    a_one_select: assert property ($onehot0(~chip_select_n))
        else $error("more than one chip select low");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_start_taken: assert property (start && !busy |=> busy)
        else $error("start not taken");
    a_idle_quiet: assert property (!busy |-> &chip_select_n && address_valid_n && output_enable_n)
        else $error("strobe low while idle");
    a_byte_pair: assert property (byte_enable0_n == byte_enable1_n)
        else $error("byte enables differ");
    a_capture_after_rise: assert property (read_valid |-> $past(bus_clock) && !$past(bus_clock, 2))
        else $error("capture not after a bus clock rise");
    a_access_bound: assert property ($rose(busy) |-> ##[2:700] done)
        else $error("access did not finish");
    a_clock_pulse: assert property (bus_clock |=> !bus_clock)
        else $error("bus clock high longer than one period");
    cover property (read_valid);
    cover property (data_out_en);
    cover property ($fell(output_enable_n));
endmodule // sync_nor_access_timing_checker
bind sync_nor_access_timing sync_nor_access_timing_checker i_chk (.clk_sys, .reset_n, .start, .busy,
    .done, .read_valid, .bus_clock, .chip_select_n, .address_valid_n, .output_enable_n,
    .byte_enable0_n, .byte_enable1_n, .io_direction, .data_out_en);
`default_nettype wire

//--- bench/test_sync_nor_access_timing.sv
// Self-checking bench for the synchronous NOR access sequencer.
// Assumes the flash model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_sync_nor_access_timing;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic profile_write = 1'b0;
    logic [2:0] profile_index = 3'h0;
    logic [71:0] profile_data = 72'h0;
    logic start = 1'b0;
    logic write_access = 1'b0;
    logic [2:0] select_index = 3'h0;
    logic [3:0] burst_length = 4'h0;
    logic [25:0] address = 26'h0;
    logic [15:0] write_data = 16'h0;
    wire busy, read_valid, done, bus_clock, address_valid_n, output_enable_n;
    wire byte_enable0_n, byte_enable1_n, io_direction, data_out_en, wait_seen;
    wire [15:0] read_data, data_out, data_in;
    wire [7:0] chip_select_n;
    wire [25:0] address_out;
    wire [3:0] wait_in;
    int checks = 0;
    int n_errors = 0;
    always #5 clk_sys = ~clk_sys;
    sync_nor_access_timing i_dut (.clk_sys, .reset_n, .profile_write, .profile_index, .profile_data,
        .start, .write_access, .select_index, .burst_length, .address, .write_data, .busy, .read_data,
        .read_valid, .done, .bus_clock, .chip_select_n, .address_valid_n, .output_enable_n,
        .byte_enable0_n, .byte_enable1_n, .io_direction, .address_out, .data_out, .data_out_en,
        .data_in, .wait_in, .wait_seen);
    flash_model i_flash (.bus_clock, .chip_select_n, .output_enable_n, .address_out, .data_in, .wait_in);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Divider 0, half-cycle delay on select only when cs_half is set: phase offsets stay zero
    task automatic set_profile(input logic [2:0] idx, input logic scale, input logic cs_half);
        @(negedge clk_sys);
        profile_write = 1'b1;
        profile_index = idx;
        profile_data = {3'h0, idx[1:0], 3'h0, cs_half, scale, 2'h0, 5'h01, 5'h01, 5'h02, 5'h0a, 5'h0b,
            5'h04, 5'h04, 5'h03, 5'h01, 5'h09, 5'h0a, 5'h01};
        @(negedge clk_sys);
        profile_write = 1'b0;
    endtask
    task automatic run(input logic wr, input logic [2:0] sel, input int n, input int s, input int h);
        int k, cs, be, adv, beats;
        logic clk_seen;
        cs = 0;
        be = 0;
        adv = 0;
        beats = 0;
        clk_seen = 1'b0;
        @(negedge clk_sys);
        start = 1'b1;
        write_access = wr;
        select_index = sel;
        burst_length = n[3:0];
        address = {18'h0, 8'hc0 | {5'h0, sel}};
        write_data = 16'h1234;
        for (k = 0; k < 800 && done !== 1'b1; k++) begin
            @(negedge clk_sys);
            // Retried start in mid-access must be ignored
            start = (k == 3);
            cs += (chip_select_n[sel] === 1'b0);
            be += (byte_enable0_n === 1'b0);
            adv += (address_valid_n === 1'b0);
            if (bus_clock === 1'b1 && !clk_seen) begin
                clk_seen = 1'b1;
                check("address", address_out, address);
            end
            if (read_valid === 1'b1 && beats < n) begin
                check("read word", read_data, {address[7:0] ^ 8'h5a, 4'h0, beats[3:0]});
                check("wait", wait_seen, 1'b1);
                beats++;
            end
            if (data_out_en === 1'b1)
                check("write word", data_out, write_data);
        end
        start = 1'b0;
        check("done", done, 1'b1);
        if (done !== 1'b1)
            summarize();
        check("select low", cs, ((wr ? 9 : 10) - 1 + (n - 1) * 2) * (s + 1) - h);
        check("byte enable low", be, ((wr ? 10 : 11) + (n - 1) * 2) * (s + 1));
        check("strobe low", adv, ((wr ? 4 : 3) - 1) * (s + 1));
        if (!wr)
            check("beats", beats, n);
        repeat (4) begin
            @(negedge clk_sys);
            check("idle", {busy, done}, 2'b00);
        end
    endtask
    task automatic single_read;
        run(1'b0, 3'h2, 1, 0, 1);
    endtask
    task automatic burst_read;
        run(1'b0, 3'h5, 4, 1, 0);
    endtask
    task automatic burst_write;
        run(1'b1, 3'h5, 4, 1, 0);
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        reset_n = 1'b1;
        // Half-cycle select delay on one profile: select asserts one period later
        set_profile(3'h2, 1'b0, 1'b1);
        set_profile(3'h5, 1'b1, 1'b0);
        single_read();
        burst_read();
        burst_write();
        summarize();
    end
endmodule // test_sync_nor_access_timing
`default_nettype wire
